// file: rtl/pmcr_pkg.sv
// Package of constants and types for the power management configuration registers.
// Function
// - Policy 00 low main, 01 adds aux, 1x off
// - Set wake flag on receive-edge deep-sleep exit
// - Bit 6 shows supply source, resets one
// - Bit 5 reads one while main supply good
// - Lock loss sets bit 4, acknowledge clears
// - Bit 3 keeps reference on in deep sleep
// - Pin function 00 gpio, 01 rx, 11 wake
// - Enable bit 7 gates supply-restored flag
// - Enable bit 5 gates sag flag
// - Enable bit 3 gates aux converter flag
// - Enable bit 2 gates battery monitor flag
// - Enable bit 1 gates switchover flag
// - Enable bit 0 gates aux low flag
// - Three scratch bytes, reset zero, retained until written
// - Summary flag set on any enabled condition
// - Restored flag set on battery-to-main change
package pmcr_pkg;
  // ********************************************************************
  // Register addresses.
  // ********************************************************************
  localparam logic [7:0] PMCR_ADDR_IRQ_EN = 8'hec;
  localparam logic [7:0] PMCR_ADDR_PERIPHERAL_CONFIG_STATUS = 8'hf4;
  localparam logic [7:0] PMCR_ADDR_SWITCH = 8'hf5;
  localparam logic [7:0] PMCR_ADDR_FLAGS = 8'hf8;
  localparam logic [7:0] PMCR_ADDR_SCR_A = 8'hfb;
  localparam logic [7:0] PMCR_ADDR_SCR_B = 8'hfc;
  localparam logic [7:0] PMCR_ADDR_SCR_C = 8'hfd;
  localparam logic [7:0] PMCR_ADDR_ADC_START = 8'hd8;
  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int PMCR_BIT_RX_WAKE = 7;
  localparam int PMCR_BIT_SRC = 6;
  localparam int PMCR_BIT_VGOOD = 5;
  localparam int PMCR_BIT_PLL = 4;
  localparam int PMCR_BIT_REFKEEP = 3;
  localparam int PMCR_BIT_RESTORE = 7;
  localparam int PMCR_BIT_SUMMARY = 6;
  localparam int PMCR_BIT_SAG = 5;
  localparam int PMCR_BIT_AUXCONV = 3;
  localparam int PMCR_BIT_BATMON = 2;
  localparam int PMCR_BIT_SWITCH = 1;
  localparam int PMCR_BIT_AUXLOW = 0;
  // Acknowledge bit inside the ADC start register; position parameterised by ACK_BIT in pmcr_regs.
  localparam int PMCR_BIT_PLL_ACK = 0;
  // ********************************************************************
  // Masks and reset values.
  // ********************************************************************
  localparam logic [7:0] PMCR_IRQ_EN_MASK = 8'haf;
  localparam logic [7:0] PMCR_PERIPHERAL_CONFIG_STATUS_WMASK = 8'h0f;
  localparam logic [7:0] PMCR_SWITCH_MASK = 8'h03;
  localparam logic [7:0] PMCR_FLAGS_MASK = 8'haf;
  localparam logic [7:0] PMCR_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] PMCR_PERIPHERAL_CONFIG_STATUS_RST = 8'h00;
  localparam logic [7:0] PMCR_SWITCH_RST = 8'h00;
  localparam logic [7:0] PMCR_SCR_RST = 8'h00;
  // Synchronised levels {source, supply good, lock lost} before real samples arrive.
  localparam logic [2:0] PMCR_LVL_RST = 3'h6;
  // Decoded control for policy 00: main-low switchover only.
  localparam logic [4:0] PMCR_CTRL_RST = 5'h10;
  localparam logic [1:0] PMCR_POLICY_MAIN = 2'h0;
  localparam logic [1:0] PMCR_POLICY_MAIN_AUX = 2'h1;
  localparam logic [1:0] PMCR_RX_GPIO = 2'h0;
  localparam logic [1:0] PMCR_RX_SERIAL = 2'h1;
  localparam logic [1:0] PMCR_RX_WAKE = 2'h3;

  // Raw condition pulses from the supply and metering monitors.
  typedef struct packed {
    logic sag;
    logic aux_conv;
    logic bat_mon;
    logic aux_low;
  } pmcr_events_t;

  // Decoded configuration for the analog and pin logic.
  typedef struct packed {
    logic switch_on_main_low;
    logic switch_on_aux_low;
    logic sleep_reference_keep;
    logic rx_as_serial;
    logic rx_wake_enable;
  } pmcr_ctrl_t;
endpackage

// file: rtl/pmcr_sync.sv
// Two-flop synchroniser for asynchronous status levels.
module pmcr_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_value,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  logic seeded_reg;
  logic seeded_next;

  if (WIDTH < 1) begin
    $error("pmcr_sync width must be positive");
  end

  always_comb begin
    meta_next = i_async;
    sync_next = seeded_reg ? meta_reg : i_reset_value;
    seeded_next = 1'b1;
  end

  // The flops reset to zero because a port may not feed the reset branch.
  // The output shows the reset value until the second edge after release,
  // so downstream edge detectors never see a false step out of reset.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      seeded_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      seeded_reg <= seeded_next;
    end
  end

  assign o_sync = seeded_reg ? sync_reg : i_reset_value;
endmodule

// file: rtl/pmcr_regs.sv
// Power management configuration, status, enable and scratch registers.
module pmcr_regs #(
  parameter int ACK_BIT = pmcr_pkg::PMCR_BIT_PLL_ACK
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic i_switched_supply_source,
  input wire logic i_main_supply_good,
  input wire logic i_pll_unlocked,
  input wire logic i_rx_edge_wake,
  input wire pmcr_pkg::pmcr_events_t i_events,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output pmcr_pkg::pmcr_ctrl_t o_ctrl,
  output logic [1:0] o_switchover_policy,
  output logic [1:0] o_rx_pin_function,
  output logic o_pm_summary_flag
);
  // ********************************************************************
  // Elaboration checks.
  // ********************************************************************
  if (ACK_BIT < 0 || ACK_BIT > 7) begin
    $error("pmcr_regs acknowledge bit must be within one byte");
  end

  // ********************************************************************
  // Input synchronisation.
  // ********************************************************************
  // The supply and PLL signals come from the analog domain and are treated
  // as asynchronous. Source and supply good read one until synchronised.
  logic [2:0] lvl_sync;
  pmcr_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_switched_supply_source, i_main_supply_good, i_pll_unlocked}),
    .i_reset_value(pmcr_pkg::PMCR_LVL_RST),
    .o_sync(lvl_sync)
  );
  logic src_s;
  logic vgood_s;
  logic pll_s;
  assign src_s = lvl_sync[2];
  assign vgood_s = lvl_sync[1];
  assign pll_s = lvl_sync[0];

  // ********************************************************************
  // Register state.
  // ********************************************************************
  logic [7:0] irq_en_reg;
  logic [7:0] irq_en_next;
  logic [7:0] peripheral_config_status_reg;
  logic [7:0] peripheral_config_status_next;
  logic [7:0] switch_reg;
  logic [7:0] switch_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] scr_reg [3];
  logic [7:0] scr_next [3];
  logic src_prev_reg;
  logic src_prev_next;
  logic pll_prev_reg;
  logic pll_prev_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic hit_reg;
  logic hit_next;
  logic summary_reg;
  logic summary_next;
  pmcr_pkg::pmcr_ctrl_t ctrl_reg;
  pmcr_pkg::pmcr_ctrl_t ctrl_next;

  function automatic logic wr_at(input logic [7:0] addr);
    wr_at = i_sfr_wr && (i_sfr_addr == addr);
  endfunction

  logic restore_evt;
  logic switch_evt;
  logic pll_ack;
  logic [7:0] set_vec;
  logic [7:0] enabled_raised;

  always_comb begin
    restore_evt = src_s && !src_prev_reg;
    switch_evt = !src_s && src_prev_reg;
    pll_ack = wr_at(pmcr_pkg::PMCR_ADDR_ADC_START) && i_sfr_wdata[ACK_BIT];
    set_vec = '0;
    set_vec[pmcr_pkg::PMCR_BIT_RESTORE] = restore_evt;
    set_vec[pmcr_pkg::PMCR_BIT_SAG] = i_events.sag;
    set_vec[pmcr_pkg::PMCR_BIT_AUXCONV] = i_events.aux_conv;
    set_vec[pmcr_pkg::PMCR_BIT_BATMON] = i_events.bat_mon;
    set_vec[pmcr_pkg::PMCR_BIT_SWITCH] = switch_evt;
    set_vec[pmcr_pkg::PMCR_BIT_AUXLOW] = i_events.aux_low;

    irq_en_next = irq_en_reg;
    if (wr_at(pmcr_pkg::PMCR_ADDR_IRQ_EN)) begin
      irq_en_next = i_sfr_wdata & pmcr_pkg::PMCR_IRQ_EN_MASK;
    end

    switch_next = switch_reg;
    if (wr_at(pmcr_pkg::PMCR_ADDR_SWITCH)) begin
      switch_next = i_sfr_wdata & pmcr_pkg::PMCR_SWITCH_MASK;
    end

    // Only the reference keep and pin function bits are writable.
    peripheral_config_status_next = peripheral_config_status_reg;
    if (wr_at(pmcr_pkg::PMCR_ADDR_PERIPHERAL_CONFIG_STATUS)) begin
      peripheral_config_status_next = i_sfr_wdata & pmcr_pkg::PMCR_PERIPHERAL_CONFIG_STATUS_WMASK;
      peripheral_config_status_next[pmcr_pkg::PMCR_BIT_RX_WAKE] = peripheral_config_status_reg[pmcr_pkg::PMCR_BIT_RX_WAKE];
      peripheral_config_status_next[pmcr_pkg::PMCR_BIT_PLL] = peripheral_config_status_reg[pmcr_pkg::PMCR_BIT_PLL];
      peripheral_config_status_next[2] = 1'b0;
    end
    if (pll_ack) begin
      peripheral_config_status_next[pmcr_pkg::PMCR_BIT_PLL] = 1'b0;
    end
    if (pll_s && !pll_prev_reg) begin
      peripheral_config_status_next[pmcr_pkg::PMCR_BIT_PLL] = 1'b1;
    end
    // Wake flag only when wakeup on the receive pin is selected.
    if (i_rx_edge_wake && peripheral_config_status_reg[1:0] == pmcr_pkg::PMCR_RX_WAKE) begin
      peripheral_config_status_next[pmcr_pkg::PMCR_BIT_RX_WAKE] = 1'b1;
    end

    // Software may clear flags; a new event in the same cycle wins.
    flags_next = flags_reg;
    if (wr_at(pmcr_pkg::PMCR_ADDR_FLAGS)) begin
      flags_next = i_sfr_wdata & pmcr_pkg::PMCR_FLAGS_MASK;
      flags_next[pmcr_pkg::PMCR_BIT_SUMMARY] =
        flags_reg[pmcr_pkg::PMCR_BIT_SUMMARY] & i_sfr_wdata[pmcr_pkg::PMCR_BIT_SUMMARY];
    end
    flags_next = flags_next | set_vec;
    enabled_raised = set_vec & irq_en_reg;
    if (|enabled_raised) begin
      flags_next[pmcr_pkg::PMCR_BIT_SUMMARY] = 1'b1;
    end

    for (int i = 0; i < 3; i++) begin
      scr_next[i] = scr_reg[i];
    end
    if (wr_at(pmcr_pkg::PMCR_ADDR_SCR_A)) begin
      scr_next[0] = i_sfr_wdata;
    end
    if (wr_at(pmcr_pkg::PMCR_ADDR_SCR_B)) begin
      scr_next[1] = i_sfr_wdata;
    end
    if (wr_at(pmcr_pkg::PMCR_ADDR_SCR_C)) begin
      scr_next[2] = i_sfr_wdata;
    end

    src_prev_next = src_s;
    pll_prev_next = pll_s;
    summary_next = flags_next[pmcr_pkg::PMCR_BIT_SUMMARY];

    ctrl_next.switch_on_main_low = !switch_next[1];
    ctrl_next.switch_on_aux_low = switch_next[1:0] == pmcr_pkg::PMCR_POLICY_MAIN_AUX;
    ctrl_next.sleep_reference_keep = peripheral_config_status_next[pmcr_pkg::PMCR_BIT_REFKEEP];
    ctrl_next.rx_as_serial = peripheral_config_status_next[0];
    ctrl_next.rx_wake_enable = peripheral_config_status_next[1:0] == pmcr_pkg::PMCR_RX_WAKE;

    // Registered read data; live status bits are merged in here.
    rdata_next = 8'h00;
    hit_next = 1'b1;
    case (i_sfr_addr)
      pmcr_pkg::PMCR_ADDR_IRQ_EN: rdata_next = irq_en_reg;
      pmcr_pkg::PMCR_ADDR_PERIPHERAL_CONFIG_STATUS: begin
        rdata_next = peripheral_config_status_reg;
        rdata_next[pmcr_pkg::PMCR_BIT_SRC] = src_s;
        rdata_next[pmcr_pkg::PMCR_BIT_VGOOD] = vgood_s;
      end
      pmcr_pkg::PMCR_ADDR_SWITCH: rdata_next = switch_reg;
      pmcr_pkg::PMCR_ADDR_FLAGS: rdata_next = flags_reg;
      pmcr_pkg::PMCR_ADDR_SCR_A: rdata_next = scr_reg[0];
      pmcr_pkg::PMCR_ADDR_SCR_B: rdata_next = scr_reg[1];
      pmcr_pkg::PMCR_ADDR_SCR_C: rdata_next = scr_reg[2];
      default: hit_next = 1'b0;
    endcase
    hit_next = hit_next && i_sfr_rd;
    if (!i_sfr_rd) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_en_reg <= pmcr_pkg::PMCR_IRQ_EN_RST;
      peripheral_config_status_reg <= pmcr_pkg::PMCR_PERIPHERAL_CONFIG_STATUS_RST;
      switch_reg <= pmcr_pkg::PMCR_SWITCH_RST;
      flags_reg <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        scr_reg[i] <= pmcr_pkg::PMCR_SCR_RST;
      end
      src_prev_reg <= 1'b1;
      pll_prev_reg <= 1'b0;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      summary_reg <= 1'b0;
      ctrl_reg <= pmcr_pkg::PMCR_CTRL_RST;
    end else begin
      irq_en_reg <= irq_en_next;
      peripheral_config_status_reg <= peripheral_config_status_next;
      switch_reg <= switch_next;
      flags_reg <= flags_next;
      for (int i = 0; i < 3; i++) begin
        scr_reg[i] <= scr_next[i];
      end
      src_prev_reg <= src_prev_next;
      pll_prev_reg <= pll_prev_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      summary_reg <= summary_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign o_sfr_rdata = rdata_reg;
  assign o_sfr_hit = hit_reg;
  assign o_ctrl = ctrl_reg;
  assign o_switchover_policy = switch_reg[1:0];
  assign o_rx_pin_function = peripheral_config_status_reg[1:0];
  assign o_pm_summary_flag = summary_reg;
endmodule

// file: bench/pmcr_regs_sva.sv
// Concurrent checks on the ports of the power management register block.
module pmcr_regs_sva (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic i_switched_supply_source,
  input wire logic i_main_supply_good,
  input wire logic i_pll_unlocked,
  input wire logic i_rx_edge_wake,
  input wire pmcr_pkg::pmcr_events_t i_events,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  input wire pmcr_pkg::pmcr_ctrl_t o_ctrl,
  input wire logic [1:0] o_switchover_policy,
  input wire logic [1:0] o_rx_pin_function,
  input wire logic o_pm_summary_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************************************************
  // Properties.
  // ********************************************************************
  wire logic mapped = i_sfr_addr inside {8'hec, 8'hf4, 8'hf5, 8'hf8, 8'hfb, 8'hfc, 8'hfd};
  wire logic [1:0] lvl = {i_switched_supply_source, i_main_supply_good};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_hit;
    i_sfr_rd && mapped |=> o_sfr_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("mapped read gave no hit");
  property p_idle;
    !i_sfr_rd |=> o_sfr_rdata == 8'h00 && !o_sfr_hit;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_unmapped;
    i_sfr_rd && !mapped && i_sfr_addr != 8'hd8 |=> !o_sfr_hit && o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_policy;
    i_sfr_wr && i_sfr_addr == 8'hf5 |=> o_switchover_policy == $past(i_sfr_wdata[1:0])
      && o_ctrl.switch_on_main_low == !o_switchover_policy[1]
      && o_ctrl.switch_on_aux_low == (o_switchover_policy == 2'h1);
  endproperty
  a_policy: assert property (p_policy) else $error("switchover decode wrong");
  property p_rxfn;
    i_sfr_wr && i_sfr_addr == 8'hf4 |=> o_rx_pin_function == $past(i_sfr_wdata[1:0])
      && o_ctrl.sleep_reference_keep == $past(i_sfr_wdata[3])
      && o_ctrl.rx_wake_enable == (o_rx_pin_function == 2'h3);
  endproperty
  a_rxfn: assert property (p_rxfn) else $error("receive pin or reference decode wrong");
  property p_scratch;
    i_sfr_wr && i_sfr_addr inside {8'hfb, 8'hfc, 8'hfd}
      ##1 i_sfr_rd && i_sfr_addr == $past(i_sfr_addr) |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch byte not kept");
  property p_sw_rsv;
    i_sfr_rd && i_sfr_addr == 8'hf5 |=> o_sfr_rdata[7:2] == 6'h00;
  endproperty
  a_sw_rsv: assert property (p_sw_rsv) else $error("switchover upper bits not zero");
  property p_en_rsv;
    i_sfr_rd && i_sfr_addr == 8'hec |=> !o_sfr_rdata[6] && !o_sfr_rdata[4];
  endproperty
  a_en_rsv: assert property (p_en_rsv) else $error("enable reserved bits not zero");
  // Levels cross a synchroniser, so only long-stable levels are compared.
  property p_live;
    i_sfr_rd && i_sfr_addr == 8'hf4 && $past(i_resetn, 4) && $past(lvl) == lvl
      && $past(lvl, 2) == lvl && $past(lvl, 3) == lvl && $past(lvl, 4) == lvl
      |=> o_sfr_rdata[6:5] == $past(lvl);
  endproperty
  a_live: assert property (p_live) else $error("supply status bits wrong");
endmodule

bind pmcr_regs pmcr_regs_sva i_pmcr_regs_sva (.i_core_clk, .i_resetn, .i_sfr_addr,
  .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .i_switched_supply_source, .i_main_supply_good,
  .i_pll_unlocked, .i_rx_edge_wake, .i_events, .o_sfr_rdata, .o_sfr_hit, .o_ctrl,
  .o_switchover_policy, .o_rx_pin_function, .o_pm_summary_flag);

// file: bench/pmcr_regs_tb.sv
// Self-checking bench for the power management register block.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module pmcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic i_switched_supply_source = 1'b1;
  logic i_main_supply_good = 1'b1;
  logic i_pll_unlocked = 1'b0;
  logic i_rx_edge_wake = 1'b0;
  pmcr_pkg::pmcr_events_t i_events = '0;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_hit;
  pmcr_pkg::pmcr_ctrl_t o_ctrl;
  logic [1:0] o_switchover_policy;
  logic [1:0] o_rx_pin_function;
  logic o_pm_summary_flag;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [8:0] q[$];
  logic [8:0] exp9;
  logic rd_d = 1'b0;
  logic [3:0] pcfg = 4'h0;
  logic pl = 1'b0;
  logic wk = 1'b0;
  logic [7:0] d;
  logic [7:0] ra[7] = '{8'hec, 8'hf4, 8'hf5, 8'hf8, 8'hfb, 8'hfc, 8'hfd};
  int pos[4] = '{0, 2, 3, 5};

  pmcr_regs i_pmcr_regs (.i_core_clk, .i_resetn, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr,
    .i_sfr_rd, .i_switched_supply_source, .i_main_supply_good, .i_pll_unlocked,
    .i_rx_edge_wake, .i_events, .o_sfr_rdata, .o_sfr_hit, .o_ctrl, .o_switchover_policy,
    .o_rx_pin_function, .o_pm_summary_flag);

  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  // ********************************************************************
  // Result monitor: each read answers on the edge after it was taken.
  // ********************************************************************
  always @(posedge i_core_clk) begin
    cyc++;
    if (rd_d) begin
      exp9 = q.pop_front();
      `CHK({o_sfr_hit, o_sfr_rdata}, exp9)
    end
    rd_d <= i_sfr_rd;
    if (cyc == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Every signal is set once per cycle, so back-to-back accesses never race.
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    i_sfr_wr = w;
    i_sfr_rd = r;
    i_sfr_addr = a;
    i_sfr_wdata = v;
    @(posedge i_core_clk);
    #2;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    q.push_back(e);
    acc(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    acc(1'b1, 1'b0, a, v);
  endtask
  task automatic idle(input int n);
    repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  function automatic logic [8:0] pe();
    return {1'b1, wk, i_switched_supply_source, i_main_supply_good, pl, pcfg};
  endfunction

  initial begin
    void'($urandom(6));
    repeat (6) @(posedge i_core_clk);
    #2;
    i_resetn = 1'b1;
    `CHK({o_ctrl, o_switchover_policy, o_rx_pin_function, o_pm_summary_flag}, 10'h200)
    for (int i = 0; i < 7; i++) rd(ra[i], i == 1 ? 9'h160 : 9'h100);
    rd(8'hfe, 9'h000);
    $display("reset values done");
    for (int i = 4; i < 7; i++) begin
      d = 8'($urandom());
      wr(ra[i], d);
      rd(ra[i], {1'b1, d});
    end
    for (int p = 0; p < 4; p++) begin
      d = {6'($urandom()), 2'(p)};
      wr(8'hf5, d);
      rd(8'hf5, {7'h40, d[1:0]});
      idle(1);
      `CHK({o_switchover_policy, o_ctrl[4:3]}, {d[1:0], ~d[1], d[1:0] == 2'h1})
    end
    for (int k = 0; k < 3; k++) begin
      d = {5'($urandom()), 1'b0, k == 2 ? 2'h3 : 2'(k)};
      wr(8'hf4, d);
      pcfg = d[3:0];
      rd(8'hf4, pe());
      idle(1);
      `CHK({o_rx_pin_function, o_ctrl[2:0]}, {d[1:0], d[3], d[0], d[1:0] == 2'h3})
    end
    $display("configuration done");
    wr(8'hec, 8'hff);
    rd(8'hec, 9'h1af);
    for (int i = 0; i < 4; i++) begin
      for (int e = 0; e < 2; e++) begin
        wr(8'hec, e ? 8'(1 << pos[i]) : 8'h00);
        wr(8'hf8, 8'h00);
        i_events = 4'(1 << i);
        idle(1);
        i_events = 4'h0;
        rd(8'hf8, {1'b1, 8'(1 << pos[i]) | (e ? 8'h40 : 8'h00)});
        `CHK(o_pm_summary_flag, 1'(e))
      end
    end
    $display("event flags done");
    wr(8'hec, 8'h82);
    wr(8'hf8, 8'h00);
    i_switched_supply_source = 1'b0;
    i_main_supply_good = 1'b0;
    idle(6);
    rd(8'hf4, pe());
    rd(8'hf8, 9'h142);
    i_switched_supply_source = 1'b1;
    i_main_supply_good = 1'b1;
    idle(6);
    rd(8'hf8, 9'h1c2);
    $display("supply source done");
    i_pll_unlocked = 1'b1;
    idle(5);
    pl = 1'b1;
    i_pll_unlocked = 1'b0;
    idle(5);
    rd(8'hf4, pe());
    wr(8'hf4, {4'h0, pcfg});
    rd(8'hf4, pe());
    wr(8'hd8, 8'h01);
    pl = 1'b0;
    rd(8'hf4, pe());
    $display("lock loss done");
    for (int f = 0; f < 4; f += 3) begin
      pcfg[1:0] = 2'(f);
      wr(8'hf4, {4'h0, pcfg});
      i_rx_edge_wake = 1'b1;
      idle(1);
      i_rx_edge_wake = 1'b0;
      wk = (f == 3);
      rd(8'hf4, pe());
    end
    $display("receive wake done");
    idle(3);
    end_of_test();
  end
endmodule
